//--- fault_supervisor.sv
// Fault protection supervisor: trip detection, cooling timers, shutdown, readout
`include "fault_defs.svh"
module fault_supervisor import fault_pkg::*; #(
  parameter int unsigned COOL_CYCLES =
    32'((64'(`COOL_TIME_MS) * 64'(`CLK_HZ)) / 64'(`MS_PER_S))
) (
  input wire logic clk,
  input wire logic rstn,
  input wire fault_vec_s trip_raw,
  input wire logic ot_release_raw,
  input wire logic sense_valid,
  input wire logic [`BAT_CODE_W-1:0] bat_code_in,
  input wire logic [`TEMP_CODE_W-1:0] temp_code_in,
  input wire reg_req_s reg_req,
  output logic [`DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output fault_vec_s flags_q,
  output logic analog_shutdown_q
);

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_TEMP,
    SEL_BAT,
    SEL_STATUS
  } reg_sel_e;

  // Decode shared by read and write paths
  function automatic reg_sel_e reg_select(input logic [`ADDR_W-1:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    case (a)
      `ADDR_TEMP_CODE: s = SEL_TEMP;
      `ADDR_BAT_CODE: s = SEL_BAT;
      `ADDR_FAULT_STATUS: s = SEL_STATUS;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  localparam logic [`COOL_CNT_W-1:0] COOL_LOAD = `COOL_CNT_W'(COOL_CYCLES);

  // Comparator outputs are analog and asynchronous
  fault_vec_s trip_meta_q;
  fault_vec_s trip_sync_q;
  logic rel_meta_q;
  logic rel_sync_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trip_meta_q <= '0;
      trip_sync_q <= '0;
      rel_meta_q <= 1'b0;
      rel_sync_q <= 1'b0;
    end else begin
      trip_meta_q <= trip_raw;
      trip_sync_q <= trip_meta_q;
      rel_meta_q <= ot_release_raw;
      rel_sync_q <= rel_meta_q;
    end
  end

  logic [`NUM_FAULTS-1:0] trip_vec;
  logic [`NUM_FAULTS-1:0] ended_vec;
  logic [`NUM_FAULTS-1:0] active_vec;
  logic [`NUM_FAULTS-1:0] set_pulse;

  assign trip_vec = trip_sync_q;
  // Voltage and current faults end when their detector drops
  assign ended_vec[`FAULT_OV] = !trip_sync_q.ov;
  assign ended_vec[`FAULT_OC] = !trip_sync_q.oc;
  assign ended_vec[`FAULT_UV] = !trip_sync_q.uv;
  // Hysteresis: the trip comparator alone would end the event too early
  assign ended_vec[`FAULT_OT] = rel_sync_q && !trip_sync_q.ot;

  for (genvar g = 0; g < `NUM_FAULTS; g++) begin : g_chan
    chan_state_e state_q;
    logic [`COOL_CNT_W-1:0] cnt_q;
    logic cool_done;
    logic cool_load;

    // Last count of the span; a zero count must not wrap
    assign cool_done = (state_q == CH_COOL) && (cnt_q <= `COOL_CNT_W'(1));
    // Fresh trip from idle, or a recheck that still finds the fault
    assign cool_load = ((state_q == CH_IDLE) && trip_vec[g])
      || ((state_q == CH_CHECK) && !ended_vec[g]);

    // One independent cooling timer per fault
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        state_q <= CH_IDLE;
      end else begin
        case (state_q)
          CH_IDLE: begin
            if (trip_vec[g]) begin
              state_q <= CH_COOL;
            end
          end
          CH_COOL: begin
            if (cool_done) begin
              state_q <= CH_CHECK;
            end
          end
          CH_CHECK: begin
            // Fault still present: start another full cooling period
            if (ended_vec[g]) begin
              state_q <= CH_IDLE;
            end else begin
              state_q <= CH_COOL;
            end
          end
          default: begin
            state_q <= CH_IDLE;
          end
        endcase
      end
    end

    // Counter runs only while cooling; rests at zero otherwise
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        cnt_q <= '0;
      end else if (cool_load) begin
        cnt_q <= COOL_LOAD;
      end else if (cool_done) begin
        cnt_q <= '0;
      end else if (state_q == CH_COOL) begin
        cnt_q <= cnt_q - `COOL_CNT_W'(1);
      end
    end

    assign active_vec[g] = (state_q != CH_IDLE);
    assign set_pulse[g] = (state_q == CH_IDLE) && trip_vec[g];
  end

  logic any_active;
  logic any_trip;

  assign any_active = |active_vec;
  // A synced trip counts at once, before its channel leaves idle
  assign any_trip = |trip_vec;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analog_shutdown_q <= 1'b0;
    end else begin
      analog_shutdown_q <= any_active || any_trip;
    end
  end

  // Sticky flags; a new trip wins over a clear in the same cycle
  logic status_wr;
  logic [`NUM_FAULTS-1:0] clr_mask;

  assign status_wr = reg_req.wr && (reg_select(reg_req.addr) == SEL_STATUS);
  assign clr_mask = status_wr ? reg_req.wdata[`NUM_FAULTS-1:0] : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr_mask) | set_pulse;
    end
  end

  // Sensor words come from converters on this clock
  logic [`BAT_CODE_W-1:0] bat_code_q;
  logic [`TEMP_CODE_W-1:0] temp_code_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bat_code_q <= `BAT_CODE_RST;
    end else if (sense_valid) begin
      bat_code_q <= bat_code_in;
    end
  end

  // Stored as given; codes outside the sensor span are not clamped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      temp_code_q <= `TEMP_CODE_RST;
    end else if (sense_valid) begin
      temp_code_q <= temp_code_in;
    end
  end

  logic [`DATA_W-1:0] status_word;
  logic [`DATA_W-1:0] rd_mux;

  always_comb begin
    status_word = `DATA_ZERO;
    status_word[`NUM_FAULTS-1:0] = flags_q;
    status_word[`ACTIVE_LSB +: `NUM_FAULTS] = active_vec;
  end

  always_comb begin
    rd_mux = `DATA_ZERO;
    case (reg_select(reg_req.addr))
      SEL_TEMP: rd_mux = {{(`DATA_W-`TEMP_CODE_W){1'b0}}, temp_code_q};
      SEL_BAT: rd_mux = {{(`DATA_W-`BAT_CODE_W){1'b0}}, bat_code_q};
      SEL_STATUS: rd_mux = status_word;
      default: rd_mux = `DATA_ZERO;
    endcase
  end

  // Answer pulse follows every read by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_req.rd;
    end
  end

  // Data holds until the next read so a slow reader still sees it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= `DATA_ZERO;
    end else if (reg_req.rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

endmodule

//--- fault_defs.svh
// Constants for the fault protection supervisor
// Operation
// - Over-voltage trip sets flag, shuts analog 200ms
// - Recheck over-voltage detector after cooling ends
// - Over-current trip sets flag, shuts analog 200ms
// - Recheck over-current detector after cooling ends
// - Under-voltage trip sets flag, shuts analog 200ms
// - Recheck under-voltage detector after cooling ends
// - Over-temperature trip shuts analog for 200ms
// - Temperature event ends only below release threshold
// - Battery code, 10 bits, readable at 0x48
// - Die temperature kelvin code readable at 0x47
// - Temperature codes span minus 40 to 175C
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

`define CLK_HZ 50000000
`define COOL_TIME_MS 200
`define MS_PER_S 1000

`define ADDR_W 8
`define DATA_W 16
`define TEMP_CODE_W 9
`define BAT_CODE_W 10
`define COOL_CNT_W 24
`define NUM_FAULTS 4

`define ADDR_TEMP_CODE 8'h47
`define ADDR_BAT_CODE 8'h48
`define ADDR_FAULT_STATUS 8'h49

`define FAULT_OV 0
`define FAULT_OC 1
`define FAULT_UV 2
`define FAULT_OT 3

`define ACTIVE_LSB 4
`define TEMP_CODE_RST 9'h000
`define BAT_CODE_RST 10'h000
`define DATA_ZERO 16'h0000

`endif

//--- fault_pkg.sv
// Types shared by the fault protection supervisor
package fault_pkg;
  `include "fault_defs.svh"

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_COOL,
    CH_CHECK
  } chan_state_e;

  typedef struct packed {
    logic ot;
    logic uv;
    logic oc;
    logic ov;
  } fault_vec_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } reg_req_s;
endpackage

//--- sensor_model.sv
// Behavioural comparators and sensors facing the supervisor
module sensor_model import fault_pkg::*; (
  input wire logic clk,
  input wire logic volt_fault,
  input wire logic amp_fault,
  input wire logic [9:0] bat,
  input wire logic [8:0] kelvin,
  output fault_vec_s trip_raw,
  output logic ot_release_raw,
  output logic sense_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  // Trip above 433 K, below 368 battery codes
  assign trip_raw = '{ot: kelvin > 9'h1B1, uv: bat < 10'h170, oc: amp_fault, ov: volt_fault};
  assign ot_release_raw = kelvin < 9'h193;
  assign sense_valid = cnt == 3'h0;
  always @(negedge clk) cnt <= cnt + 3'h1;
endmodule

//--- fault_monitor.sv
// Port assertions for the fault supervisor
module fault_monitor import fault_pkg::*; #(
  parameter int unsigned COOL_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire reg_req_s reg_req,
  input wire logic reg_rvalid_q,
  input wire fault_vec_s flags_q,
  input wire logic analog_shutdown_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [31:0] hi_cnt;
  // Length of the current shutdown run, in samples
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 32'h00000000;
    end else if (analog_shutdown_q) begin
      hi_cnt <= hi_cnt + 32'h00000001;
    end else begin
      hi_cnt <= 32'h00000000;
    end
  end
  property p_cool; $fell(analog_shutdown_q) |-> hi_cnt >= COOL_CYCLES; endproperty
  a_cool: assert property (p_cool) else $error("cooling span too short");
  property p_volt; $rose(flags_q.ov) |-> analog_shutdown_q; endproperty
  a_volt: assert property (p_volt) else $error("volt trip no shutdown");
  property p_amp; $rose(flags_q.oc) |-> analog_shutdown_q; endproperty
  a_amp: assert property (p_amp) else $error("amp trip no shutdown");
  property p_batt; $rose(flags_q.uv) |-> analog_shutdown_q; endproperty
  a_batt: assert property (p_batt) else $error("batt trip no shutdown");
  property p_heat; $rose(flags_q.ot) |-> analog_shutdown_q; endproperty
  a_heat: assert property (p_heat) else $error("heat trip no shutdown");
  property p_hold; $rose(analog_shutdown_q) |-> analog_shutdown_q[*8]; endproperty
  a_hold: assert property (p_hold) else $error("cooling too short");
  property p_keep;
    $fell(flags_q.ov) |-> $past(reg_req.wr) && ($past(reg_req.addr) == 8'h49)
      && $past(reg_req.wdata[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost without clear");
  property p_ans; reg_req.rd |=> reg_rvalid_q; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_only; reg_rvalid_q |-> $past(reg_req.rd); endproperty
  a_only: assert property (p_only) else $error("answer without read");
  cover property ($rose(flags_q.ot));
  cover property ($fell(flags_q.ov));
  cover property ($fell(analog_shutdown_q));
  cover property ($fell(analog_shutdown_q) && hi_cnt < 32'h0000001E);
endmodule
bind fault_supervisor fault_monitor #(.COOL_CYCLES(COOL_CYCLES)) mon_u (.clk(clk), .rstn(rstn),
  .reg_req(reg_req), .reg_rvalid_q(reg_rvalid_q), .flags_q(flags_q),
  .analog_shutdown_q(analog_shutdown_q));

//--- tb.sv
// Self-checking bench for the fault supervisor
module tb import fault_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, volt_fault = 1'b0, amp_fault = 1'b0;
  logic [9:0] bat = 10'h260;
  logic [8:0] kelvin = 9'h12A;
  reg_req_s req = '0;
  fault_vec_s trip_raw, flags_q;
  logic ot_release_raw, sense_valid, reg_rvalid_q, analog_shutdown_q;
  logic [15:0] reg_rdata_q;
  int error_cnt = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  sensor_model model_u (.clk(clk), .volt_fault(volt_fault), .amp_fault(amp_fault), .bat(bat),
    .kelvin(kelvin), .trip_raw(trip_raw), .ot_release_raw(ot_release_raw),
    .sense_valid(sense_valid));
  // Short cooling keeps the run brief
  fault_supervisor #(.COOL_CYCLES(20)) dut_u (.clk(clk), .rstn(rstn), .trip_raw(trip_raw),
    .ot_release_raw(ot_release_raw), .sense_valid(sense_valid), .bat_code_in(bat),
    .temp_code_in(kelvin), .reg_req(req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .flags_q(flags_q), .analog_shutdown_q(analog_shutdown_q));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk) req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge clk) req = '0;
    chk({15'h0000, reg_rvalid_q}, 16'h0001);
    chk(reg_rdata_q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk) req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk) req = '0;
  endtask
  task automatic set_fault(input int i, input logic on);
    @(negedge clk);
    case (i)
      0: volt_fault = on;
      1: amp_fault = on;
      2: bat = on ? 10'h12C : 10'h260;
      default: kelvin = on ? 9'h1B8 : 9'h12A;
    endcase
  endtask
  task automatic t_readout;
    rd(8'h48, 16'h0260);
    rd(8'h47, 16'h012A);
    wr(8'h48, 16'h0000);
    rd(8'h48, 16'h0260);
    rd(8'h50, 16'h0000);
  endtask
  task automatic t_pulse;
    set_fault(0, 1'b1);
    set_fault(0, 1'b0);
    // Fault gone long before the cooling span ends
    repeat (18) @(negedge clk);
    chk({15'h0000, analog_shutdown_q}, 16'h0001);
    repeat (10) @(negedge clk);
    chk({15'h0000, analog_shutdown_q}, 16'h0000);
    chk({12'h000, flags_q}, 16'h0001);
    wr(8'h49, 16'h0001);
    chk({12'h000, flags_q}, 16'h0000);
  endtask
  task automatic t_fault(input int i);
    set_fault(i, 1'b1);
    // Fault still present after one cooling span
    repeat (30) @(negedge clk);
    chk({15'h0000, analog_shutdown_q}, 16'h0001);
    rd(8'h49, 16'h0011 << i);
    if (i == 2) rd(8'h48, 16'h012C);
    if (i == 3) begin
      kelvin = 9'h1A4;
      repeat (50) @(negedge clk);
      chk({15'h0000, analog_shutdown_q}, 16'h0001);
    end
    set_fault(i, 1'b0);
    repeat (50) @(negedge clk);
    chk({15'h0000, analog_shutdown_q}, 16'h0000);
    chk({12'h000, flags_q}, 16'h0001 << i);
    wr(8'h49, 16'h0001 << i);
    chk({12'h000, flags_q}, 16'h0000);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    t_readout();
    t_pulse();
    for (int i = 0; i < 4; i++) t_fault(i);
    stop_test();
  end
  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end
endmodule
